// ===== hw/spcm_serial_port.sv
// Strobed PCM serial port with APB register access and bit-clock link logic.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps

// Functional notes
// - Strobe marks one shared 8-bit timeslot.
// - Transmit bits change on rising bit clock.
// - Receive bits captured on falling bit clock.
// - Serial output is three-state, released when idle.
// - Law pin high A-law, low mu-law.
// - Transmit mute sends negative-zero code.
// - Speed select fixes rate and converter division.
// - Internal timing derived from clock input.
// - Power-up reset low restores initial state.
// - Receive mute feeds quiet code to decoder.
// - Quiet code 0x7f mu-law, 0x55 A-law.
// - Speed-select encodings map to listed rates; the 128 and 256 encodings get the 4096 division of 8 edges.
// - Output high impedance while strobe inactive.
module spcm_serial_port
(
   // System clock, reset and enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [spcm_pkg::ADDR_W-1:0] paddr,
   input wire logic [spcm_pkg::DATA_W-1:0] pwdata,
   output logic [spcm_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Control pins.
   input wire logic powerUpReset_n,
   input wire logic lawSelect,
   input wire logic transmitMute,
   input wire logic receiveMute,
   input wire logic [spcm_pkg::SEL_W-1:0] speedSel,
   input wire logic clockInput,
   // Serial link.
   input wire logic bitClock,
   input wire logic frameStrobe,
   input wire logic serialDataIn,
   output logic serialDataOut,
   output logic serialDataOutEn_n,
   // Decoder side.
   output logic [spcm_pkg::SAMPLE_W-1:0] rxSample,
   output logic rxSampleValid,
   output logic converterTick
);
   import spcm_pkg::*;

   typedef struct packed {
      logic pwr1;
      logic pwr2;
      logic law1;
      logic law2;
      logic rxm1;
      logic rxm2;
      logic txm1;
      logic txm2;
      logic [SEL_W-1:0] sel1;
      logic [SEL_W-1:0] sel2;
      logic ck1;
      logic ck2;
      logic ck3;
      logic rxTog1;
      logic rxTog2;
      logic rxTog3;
      logic linkRstReq;
      logic [SAMPLE_W-1:0] txWord;
      logic txToggle;
      logic [SAMPLE_W-1:0] rxSample;
      logic rxValid;
      logic [DIV_W-1:0] divCnt;
      logic tick;
      logic [FRAME_W-1:0] frames;
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } spcm_sys_t;

   typedef struct packed {
      logic rst1;
      logic rst2;
      logic ce1;
      logic ce2;
      logic tog1;
      logic tog2;
      logic tog3;
      logic txm1;
      logic txm2;
      logic law1;
      logic law2;
      logic [SAMPLE_W-1:0] txHold;
      spcm_link_state_t state;
      logic [SAMPLE_W-1:0] txShift;
      logic [CNT_W-1:0] bitCnt;
      logic dout;
      logic oeN;
   } spcm_link_t;

   typedef struct packed {
      logic [SAMPLE_W-1:0] rxShift;
      logic [CNT_W-1:0] rxCnt;
      logic [SAMPLE_W-1:0] rxWord;
      logic rxToggle;
   } spcm_rx_t;

   localparam spcm_sys_t SYS_RST = '{txWord: TX_WORD_RESET, rxSample: RX_SAMPLE_RESET, linkRstReq: 1'b1,
                                     default: '0};
   localparam spcm_link_t LINK_RST = '{rst1: 1'b1, rst2: 1'b1, txHold: TX_WORD_RESET, state: LINK_IDLE,
                                       oeN: 1'b1, default: '0};
   localparam spcm_rx_t RX_RST = '{default: '0};

   spcm_sys_t s_reg, s_next;
   spcm_link_t l_reg, l_next;
   spcm_rx_t r_reg, r_next;
   logic [SAMPLE_W-1:0] rxNextWord;
   logic ckEdge;
   logic setupPhase;
   logic writeTaken;

   assign rxNextWord = {r_reg.rxShift[SAMPLE_W-2:0], serialDataIn};
   assign ckEdge = s_reg.ck2 & ~s_reg.ck3;
   assign setupPhase = psel & ~penable;
   assign writeTaken = psel & penable & pwrite & s_reg.pready;

   // System domain: pin synchronisers, APB, converter tick and receive hand-over.
   always_comb
   begin
      s_next = s_reg;
      s_next.pwr1 = powerUpReset_n;
      s_next.pwr2 = s_reg.pwr1;
      s_next.law1 = lawSelect;
      s_next.law2 = s_reg.law1;
      s_next.rxm1 = receiveMute;
      s_next.rxm2 = s_reg.rxm1;
      s_next.txm1 = transmitMute;
      s_next.txm2 = s_reg.txm1;
      s_next.sel1 = speedSel;
      s_next.sel2 = s_reg.sel1;
      s_next.ck1 = clockInput;
      s_next.ck2 = s_reg.ck1;
      s_next.ck3 = s_reg.ck2;
      s_next.rxTog1 = r_reg.rxToggle;
      s_next.rxTog2 = s_reg.rxTog1;
      s_next.rxTog3 = s_reg.rxTog2;
      s_next.linkRstReq = 1'b0;
      s_next.rxValid = 1'b0;
      s_next.tick = 1'b0;
      s_next.pready = setupPhase;
      s_next.pslverr = 1'b0;
      s_next.prdata = '0;
      // The converter tick counts clock-input edges, so its rate follows the pin, not clk.
      if (ckEdge)
      begin
         if (s_reg.divCnt >= divRatio(s_reg.sel2) - DIV_ONE)
         begin
            s_next.divCnt = '0;
            s_next.tick = 1'b1;
         end
         else
         begin
            s_next.divCnt = s_reg.divCnt + DIV_ONE;
         end
      end
      if (s_reg.rxTog2 != s_reg.rxTog3)
      begin
         s_next.rxSample = s_reg.rxm2 ? quietCode(s_reg.law2) : r_reg.rxWord;
         s_next.rxValid = 1'b1;
         s_next.frames = s_reg.frames + 16'h0001;
      end
      if (setupPhase)
      begin
         if (paddr == TX_DATA_OFFSET)
         begin
            s_next.prdata[SAMPLE_W-1:0] = s_reg.txWord;
         end
         else if (paddr == RX_DATA_OFFSET)
         begin
            s_next.prdata[SAMPLE_W-1:0] = s_reg.rxSample;
         end
         else if (paddr == STATUS_OFFSET)
         begin
            s_next.prdata[STAT_SEL_LSB +: SEL_W] = s_reg.sel2;
            s_next.prdata[STAT_RECEIVE_MUTE_BIT] = s_reg.rxm2;
            s_next.prdata[STAT_LAW_BIT] = s_reg.law2;
            s_next.prdata[STAT_SELBAD_BIT] = ~selValid(s_reg.sel2);
            s_next.prdata[STAT_TRANSMIT_MUTE_BIT] = s_reg.txm2;
            s_next.prdata[STAT_FRAMES_LSB +: FRAME_W] = s_reg.frames;
         end
         else
         begin
            s_next.pslverr = 1'b1;
         end
      end
      // The link copies txWord on the toggle, so software should write at most once per frame.
      if (writeTaken && paddr == TX_DATA_OFFSET)
      begin
         s_next.txWord = pwdata[SAMPLE_W-1:0];
         s_next.txToggle = ~s_reg.txToggle;
      end
      if (!s_reg.pwr2)
      begin
         s_next = SYS_RST;
         s_next.pwr1 = powerUpReset_n;
         s_next.pwr2 = s_reg.pwr1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_reg <= SYS_RST;
      end
      else if (clkEn)
      begin
         s_reg <= s_next;
      end
   end

   // Link domain, rising bit-clock edge: transmit slot.
   always_comb
   begin
      l_next = l_reg;
      l_next.rst1 = s_reg.linkRstReq;
      l_next.rst2 = l_reg.rst1;
      l_next.ce1 = clkEn;
      l_next.ce2 = l_reg.ce1;
      l_next.tog1 = s_reg.txToggle;
      l_next.tog2 = l_reg.tog1;
      l_next.tog3 = l_reg.tog2;
      l_next.txm1 = transmitMute;
      l_next.txm2 = l_reg.txm1;
      l_next.law1 = lawSelect;
      l_next.law2 = l_reg.law1;
      if (l_reg.tog2 != l_reg.tog3)
      begin
         l_next.txHold = s_reg.txWord;
      end
      if (!frameStrobe)
      begin
         l_next.state = LINK_IDLE;
         l_next.bitCnt = '0;
         l_next.oeN = 1'b1;
      end
      else
      begin
         case (l_reg.state)
            LINK_IDLE:
            begin
               l_next.txShift = l_reg.txm2 ? quietCode(l_reg.law2) : l_reg.txHold;
               l_next.dout = l_next.txShift[SAMPLE_W-1];
               l_next.txShift = {l_next.txShift[SAMPLE_W-2:0], 1'b0};
               l_next.bitCnt = 4'h1;
               l_next.oeN = 1'b0;
               l_next.state = LINK_SLOT;
            end
            LINK_SLOT:
            begin
               if (l_reg.bitCnt == BITS_PER_SLOT)
               begin
                  l_next.state = LINK_DONE;
               end
               else
               begin
                  l_next.dout = l_reg.txShift[SAMPLE_W-1];
                  l_next.txShift = {l_reg.txShift[SAMPLE_W-2:0], 1'b0};
                  l_next.bitCnt = l_reg.bitCnt + 4'h1;
               end
            end
            LINK_DONE:
            begin
               l_next.state = LINK_DONE;
            end
            default:
            begin
               l_next.state = LINK_IDLE;
            end
         endcase
      end
      if (l_reg.rst2)
      begin
         l_next = LINK_RST;
         l_next.rst1 = s_reg.linkRstReq;
         l_next.rst2 = l_reg.rst1;
      end
      else if (!l_reg.ce2)
      begin
         l_next.txHold = l_reg.txHold;
         l_next.state = l_reg.state;
         l_next.txShift = l_reg.txShift;
         l_next.bitCnt = l_reg.bitCnt;
         l_next.dout = l_reg.dout;
         l_next.oeN = l_reg.oeN;
      end
   end

   always_ff @(posedge bitClock)
   begin
      l_reg <= l_next;
   end

   // Link domain, falling bit-clock edge: receive slot.
   always_comb
   begin
      r_next = r_reg;
      if (!frameStrobe)
      begin
         r_next.rxCnt = '0;
      end
      else if (r_reg.rxCnt < BITS_PER_SLOT)
      begin
         r_next.rxShift = rxNextWord;
         r_next.rxCnt = r_reg.rxCnt + 4'h1;
         if (r_reg.rxCnt == LAST_RX_BIT)
         begin
            r_next.rxWord = rxNextWord;
            r_next.rxToggle = ~r_reg.rxToggle;
         end
      end
      if (l_reg.rst2)
      begin
         r_next = RX_RST;
      end
      else if (!l_reg.ce2)
      begin
         r_next = r_reg;
      end
   end

   always_ff @(negedge bitClock)
   begin
      r_reg <= r_next;
   end

   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign serialDataOut = l_reg.dout;
   assign serialDataOutEn_n = l_reg.oeN;
   assign rxSample = s_reg.rxSample;
   assign rxSampleValid = s_reg.rxValid;
   assign converterTick = s_reg.tick;

   a_oe_idle_release: assert property (@(posedge bitClock) disable iff (l_reg.rst2)
      (!frameStrobe && l_reg.ce2) |=> l_reg.oeN)
      else $error("Serial output driven outside the strobe.");
   a_tx_first_bit: assert property (@(posedge bitClock) disable iff (l_reg.rst2)
      (frameStrobe && l_reg.ce2 && l_reg.state == LINK_IDLE && !l_reg.txm2)
      |=> (!l_reg.oeN && {l_reg.dout, l_reg.txShift[SAMPLE_W-1:1]} == $past(l_reg.txHold)))
      else $error("Transmit word not started MSB first.");
   a_tx_mute_quiet: assert property (@(posedge bitClock) disable iff (l_reg.rst2)
      (frameStrobe && l_reg.ce2 && l_reg.state == LINK_IDLE && l_reg.txm2)
      |=> ({l_reg.dout, l_reg.txShift[SAMPLE_W-1:1]} == quietCode($past(l_reg.law2))))
      else $error("Muted transmit did not send the quiet code.");
   a_slot_bit_count: assert property (@(posedge bitClock) disable iff (l_reg.rst2)
      (l_reg.state == LINK_SLOT && frameStrobe && l_reg.ce2 && l_reg.bitCnt == BITS_PER_SLOT)
      |=> (l_reg.state == LINK_DONE && l_reg.dout == $past(l_reg.dout)))
      else $error("Slot did not stop after eight bits.");
   a_rx_word_done: assert property (@(negedge bitClock) disable iff (l_reg.rst2)
      (frameStrobe && l_reg.ce2 && r_reg.rxCnt == LAST_RX_BIT)
      |=> (r_reg.rxWord == $past(rxNextWord) && r_reg.rxToggle != $past(r_reg.rxToggle)))
      else $error("Receive word not completed on the eighth falling edge.");
   a_rx_mute_quiet: assert property (@(posedge clk) disable iff (rst)
      (clkEn && s_reg.pwr2 && s_reg.rxTog2 != s_reg.rxTog3 && s_reg.rxm2)
      |=> (s_reg.rxValid && s_reg.rxSample == quietCode($past(s_reg.law2))))
      else $error("Muted receive did not present the quiet code.");
   a_tick_ratio: assert property (@(posedge clk) disable iff (rst)
      (clkEn && s_reg.pwr2 && ckEdge && s_reg.divCnt == divRatio(s_reg.sel2) - DIV_ONE) |=> s_reg.tick)
      else $error("Converter tick missed at the selected ratio.");
   a_tick_cause: assert property (@(posedge clk) disable iff (rst)
      s_reg.tick |-> $past(ckEdge))
      else $error("Converter tick without a clock-input edge.");
   a_pwr_reset: assert property (@(posedge clk) disable iff (rst)
      (clkEn && !s_reg.pwr2) |=> (s_reg.txWord == TX_WORD_RESET && s_reg.frames == '0 && s_reg.linkRstReq))
      else $error("Power-up reset did not restore the initial state.");
   a_apb_unmapped: assert property (@(posedge clk) disable iff (rst)
      (clkEn && s_reg.pwr2 && setupPhase && paddr != TX_DATA_OFFSET && paddr != RX_DATA_OFFSET
       && paddr != STATUS_OFFSET) |=> (pready && pslverr))
      else $error("Unmapped access not answered with an error.");

endmodule // spcm_serial_port

// ===== common/spcm_pkg.sv
// Shared constants, types and helpers of the strobed PCM serial port.
package spcm_pkg;

   // Widths.
   localparam int DATA_W = 32;
   localparam int ADDR_W = 12;
   localparam int SAMPLE_W = 8;
   localparam int SEL_W = 3;
   localparam int DIV_W = 4;
   localparam int CNT_W = 4;
   localparam int FRAME_W = 16;
   localparam logic [CNT_W-1:0] BITS_PER_SLOT = 4'h8;
   localparam logic [CNT_W-1:0] LAST_RX_BIT = 4'h7;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] TX_DATA_OFFSET = 12'h000;
   localparam logic [ADDR_W-1:0] RX_DATA_OFFSET = 12'h004;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h008;

   // Status field positions.
   localparam int STAT_SEL_LSB = 0;
   localparam int STAT_RECEIVE_MUTE_BIT = 3;
   localparam int STAT_LAW_BIT = 4;
   localparam int STAT_SELBAD_BIT = 5;
   localparam int STAT_TRANSMIT_MUTE_BIT = 6;
   localparam int STAT_FRAMES_LSB = 16;

   // Negative-zero (quiet) codes and reset values.
   localparam logic [SAMPLE_W-1:0] QUIET_MULAW = 8'h7f;
   localparam logic [SAMPLE_W-1:0] QUIET_ALAW = 8'h55;
   localparam logic [SAMPLE_W-1:0] TX_WORD_RESET = 8'h7f;
   localparam logic [SAMPLE_W-1:0] RX_SAMPLE_RESET = 8'h7f;

   // Speed-select encodings {sel2,sel1,sel0}.
   localparam logic [SEL_W-1:0] SEL_512 = 3'h0;
   localparam logic [SEL_W-1:0] SEL_1536 = 3'h1;
   localparam logic [SEL_W-1:0] SEL_2048 = 3'h2;
   localparam logic [SEL_W-1:0] SEL_4096 = 3'h3;
   localparam logic [SEL_W-1:0] SEL_128 = 3'h4;
   localparam logic [SEL_W-1:0] SEL_256 = 3'h5;

   // Clock-input edges per 512 kHz converter tick.
   localparam logic [DIV_W-1:0] DIV_512 = 4'h1;
   localparam logic [DIV_W-1:0] DIV_1536 = 4'h3;
   localparam logic [DIV_W-1:0] DIV_2048 = 4'h4;
   localparam logic [DIV_W-1:0] DIV_4096 = 4'h8;
   localparam logic [DIV_W-1:0] DIV_ONE = 4'h1;

   typedef enum logic [2:0] {
      LINK_IDLE = 3'b001,
      LINK_SLOT = 3'b010,
      LINK_DONE = 3'b100
   } spcm_link_state_t;

   function automatic logic [SAMPLE_W-1:0] quietCode(input logic aLaw);
      quietCode = aLaw ? QUIET_ALAW : QUIET_MULAW;
   endfunction

   function automatic logic [DIV_W-1:0] divRatio(input logic [SEL_W-1:0] sel);
      case (sel)
         SEL_512: divRatio = DIV_512;
         SEL_1536: divRatio = DIV_1536;
         SEL_2048: divRatio = DIV_2048;
         default: divRatio = DIV_4096;
      endcase
   endfunction

   function automatic logic selValid(input logic [SEL_W-1:0] sel);
      selValid = (sel <= SEL_256);
   endfunction

endpackage

// ===== tb/spcm_far_end.sv
// Model of the far-end transmission device that drives the bit clock, the strobe and the serial input.
`timescale 1ns/1ps
module spcm_far_end
(
   // Clocks and strobe.
   output logic bitClock,
   output logic frameStrobe,
   output logic clockInput,
   // Serial data.
   output logic serialDataIn,
   input wire logic serialDataOut,
   input wire logic serialDataOutEn_n
);
   initial
   begin
      bitClock = 1'b0;
      frameStrobe = 1'b0;
      clockInput = 1'b0;
      serialDataIn = 1'b1;
   end
   // The bit clock stands still between calls, so nothing in the link may rely on it running free.
   task automatic idle(input int n);
      repeat (n)
      begin
         #32 bitClock = 1'b1;
         #32 bitClock = 1'b0;
      end
   endtask
   task automatic slot(input logic [7:0] txB, output logic [7:0] rxB, output logic drove);
      drove = 1'b1;
      idle(4);
      // The strobe moves inside the low phase, 16 ns after the falling edge, so neither clock edge races it.
      #16 frameStrobe = 1'b1;
      for (int i = 7; i >= 0; i--)
      begin
         #16 bitClock = 1'b1;
         serialDataIn = txB[i];
         #32 rxB[i] = serialDataOut;
         drove &= (serialDataOutEn_n === 1'b0);
         bitClock = 1'b0;
         #16;
      end
      frameStrobe = 1'b0;
      // A released line keeps no value, so the inverse is shown.
      serialDataIn = ~serialDataIn;
      idle(1);
   endtask
   // A slow master clock stands in for the converter clock source.
   task automatic master(input int n);
      repeat (n)
      begin
         #250 clockInput = 1'b1;
         #250 clockInput = 1'b0;
      end
   endtask
endmodule // spcm_far_end

// ===== tb/tb_top.sv
// Self-checking testbench of the strobed PCM serial port.
`timescale 1ns/1ps
module tb_top;
   import spcm_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, err, drove, gotValid, counting;
   logic powerUpReset_n, lawSelect, transmitMute, receiveMute, clockInput, bitClock, frameStrobe;
   logic serialDataIn, serialDataOut, serialDataOutEn_n, rxSampleValid, converterTick;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [SEL_W-1:0] speedSel;
   logic [SAMPLE_W-1:0] rxSample, seen;
   int nFail, nChecks, ticks;
   int expTicks[8] = '{24, 8, 6, 3, 3, 3, 3, 3};

   spcm_serial_port spcm_serial_port_i (.clk(clk), .rst(rst), .clkEn(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .powerUpReset_n(powerUpReset_n), .lawSelect(lawSelect),
      .transmitMute(transmitMute), .receiveMute(receiveMute), .speedSel(speedSel),
      .clockInput(clockInput), .bitClock(bitClock), .frameStrobe(frameStrobe),
      .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
      .serialDataOutEn_n(serialDataOutEn_n), .rxSample(rxSample), .rxSampleValid(rxSampleValid),
      .converterTick(converterTick));
   spcm_far_end spcm_far_end_i (.bitClock(bitClock), .frameStrobe(frameStrobe),
      .clockInput(clockInput), .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
      .serialDataOutEn_n(serialDataOutEn_n));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (rxSampleValid === 1'b1) gotValid <= 1'b1;
      if (counting && converterTick === 1'b1) ticks <= ticks + 1;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         nFail++;
         $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask

   // The request is held until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic frame(input logic [7:0] txB, input logic [7:0] expTx, input logic [7:0] expRx);
      #5 gotValid = 1'b0;
      spcm_far_end_i.slot(txB, seen, drove);
      check(seen, expTx);
      check(drove, 1'b1);
      #40 check(serialDataOutEn_n, 1'b1);
      repeat (10) @(posedge clk);
      check(gotValid, 1'b1);
      check(rxSample, expRx);
   endtask

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", nChecks, nFail);
      if (nFail == 0 && nChecks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      #1000000;
      nFail++;
      $display("Error at %0t ns: watchdog expired", $time);
      summarize();
   end

   initial
   begin
      {rst, powerUpReset_n} = 2'b11;
      {psel, penable, pwrite, lawSelect, transmitMute, receiveMute, counting} = '0;
      paddr = '0;
      pwdata = '0;
      speedSel = SEL_512;
      {ticks, nFail, nChecks, gotValid} = '0;
      // The bit clock keeps running past the release so the link sees the reset request.
      fork
         spcm_far_end_i.idle(8);
         begin
            repeat (8) @(posedge clk);
            rst <= 1'b0;
         end
      join
      apb(1'b0, TX_DATA_OFFSET, '0);
      check(rd, 32'h7f);
      apb(1'b0, RX_DATA_OFFSET, '0);
      check(rd, 32'h7f);
      apb(1'b1, 12'h00c, 32'h1);
      check(err, 1'b1);
      $display("Test reset values done");
      apb(1'b1, TX_DATA_OFFSET, 32'ha5);
      frame(8'h3c, 8'ha5, 8'h3c);
      apb(1'b0, RX_DATA_OFFSET, '0);
      check(rd, 32'h3c);
      $display("Test plain slot done");
      for (int law = 0; law < 2; law++)
      begin
         @(posedge clk);
         lawSelect <= law[0];
         transmitMute <= 1'b1;
         receiveMute <= 1'b1;
         repeat (3) @(posedge clk);
         apb(1'b0, STATUS_OFFSET, '0);
         check(rd[6:0], {1'b1, 1'b0, law[0], 1'b1, 3'h0});
         frame(8'hc3, law ? QUIET_ALAW : QUIET_MULAW, law ? QUIET_ALAW : QUIET_MULAW);
      end
      @(posedge clk);
      {lawSelect, transmitMute, receiveMute} <= 3'h0;
      $display("Test mute and law done");
      for (int s = 0; s < 8; s++)
      begin
         @(posedge clk);
         speedSel <= s[2:0];
         #5 spcm_far_end_i.master(16);
         counting = 1'b1;
         ticks = 0;
         spcm_far_end_i.master(24);
         counting = 1'b0;
         check(ticks, expTicks[s]);
         apb(1'b0, STATUS_OFFSET, '0);
         check(rd[5:0], {s > 5, 2'b00, s[2:0]});
         check(rd[31:16], 32'h00000003);
      end
      $display("Test speed select done");
      @(posedge clk);
      speedSel <= SEL_512;
      apb(1'b1, TX_DATA_OFFSET, 32'h11);
      powerUpReset_n <= 1'b0;
      fork
         spcm_far_end_i.idle(8);
         repeat (8) @(posedge clk);
      join
      @(posedge clk);
      powerUpReset_n <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, TX_DATA_OFFSET, '0);
      check(rd, 32'h7f);
      frame(8'h00, TX_WORD_RESET, 8'h00);
      $display("Test power-up reset done");
      summarize();
   end
endmodule // tb_top
